//--- include/host_bus_defs.svh
// Purpose: named constants for the host bus pin interface
// Assumes: SYS_CLK at 100 MHz
// Notes: register offsets are byte addresses on the APB slave
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH

`define SYS_CLK_PERIOD_NS 10
`define ROM_CLK_PERIOD_NS 4000
`define ROM_HALF_CYCLES (`ROM_CLK_PERIOD_NS / (2 * `SYS_CLK_PERIOD_NS))
`define ROM_DIV_W 8
`define ROM_WARM_CYCLES 8'h03
`define ROM_CMD_BITS 5'h09
`define ROM_CMD_WORD 9'h180
`define ROM_CMD_MSB 8
`define ROM_DATA_BITS 5'h10
`define ROM_WIDTH_BIT 0
`define ASYNC_WAIT_CYCLES 4'h4
`define ADDR_CMP_HI 15
`define ADDR_CMP_LO 4

`define APB_ADDR_W 12
`define REG_CTRL 12'h000
`define REG_BASE 12'h004
`define REG_STATUS 12'h008
`define REG_ROM_WORD 12'h00c
`define REG_INT_STATUS 12'h010
`define REG_INT_MASK 12'h014

`define CTRL_LATCH_BIT 0
`define BASE_RESET 16'h0300
`define INT_W 4
`define INT_CFG_DONE 0
`define INT_READ 1
`define INT_WRITE 2
`define INT_SYNC 3

`endif

//--- include/host_bus_pkg.sv
// Purpose: types shared by the host bus pin interface
// Assumes: nothing beyond the defs header
// Notes: enum codes are one-hot
package host_bus_pkg;

  typedef enum logic [4:0] {
    ROM_IDLE = 5'b00001,
    ROM_STRAP = 5'b00010,
    ROM_CMD = 5'b00100,
    ROM_DATA = 5'b01000,
    ROM_DONE = 5'b10000
  } rom_state_t;

  typedef enum logic [2:0] {
    B_IDLE = 3'b001,
    B_CMD = 3'b010,
    B_READY = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic [15:1] addr;
    logic qual_n;
    logic ads_n;
    logic rd_n;
    logic wr_n;
    logic wnr;
    logic cyc_n;
    logic rdy_ret_n;
    logic bus_clk;
    logic mode_n;
    logic rom_en;
    logic rom_in;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic bclk_d;
    logic ads_d;
    logic acc_d;
    logic [15:1] lat_addr;
    logic lat_qual_n;
    rom_state_t rom;
    logic [7:0] div;
    logic sk;
    logic [4:0] bitcnt;
    logic [8:0] cmd_sh;
    logic [15:0] rom_word;
    logic do_bit;
    logic cs;
    logic done;
    logic mode_n;
    logic rom_en;
    logic bus16;
    bus_state_t bus;
    logic srdy_n;
    logic [3:0] wait_cnt;
    logic async_wait_ready_drive;
    logic [31:0] prdata;
    logic pslverr;
    logic [3:0] rd_clr;
    logic latch_mode;
    logic [15:0] base;
    logic [3:0] ist;
    logic [3:0] imask;
  } state_t;

endpackage

//--- verilog/host_bus_port.sv
// Purpose: host bus pin logic: decode, ready, straps, config ROM load, APB registers
// Assumes: host pins are asynchronous to SYS_CLK; BUS_CLK is sampled, not used as a clock
// Notes: open-drain pins are driven low only, via _OUT/_OE pairs
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "host_bus_defs.svh"

module host_bus_port
  import host_bus_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BUS_CLK,
  input wire logic [15:1] ADDRESS,
  input wire logic ADDRESS_QUALIFIER_N,
  input wire logic ADDRESS_LATCH_STROBE_N,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic SYNC_WRITE_NOT_READ,
  input wire logic COMMAND_CYCLE_N,
  input wire logic READY_RETURN_IN_N,
  input wire logic SYNC_BUS_MODE_STRAP_N,
  input wire logic CONFIG_ROM_ENABLE_STRAP,
  input wire logic CONFIG_ROM_SERIAL_IN,
  output logic IRQ_OUT_N_OUT,
  output logic IRQ_OUT_N_OE,
  output logic LOCAL_DEVICE_SELECT_N_OUT,
  output logic LOCAL_DEVICE_SELECT_N_OE,
  output logic ASYNC_WAIT_READY_OUT,
  output logic ASYNC_WAIT_READY_OE,
  output logic SYNC_READY_OUT_N,
  output logic CONFIG_ROM_SELECT,
  output logic CONFIG_ROM_SERIAL_CLOCK,
  output logic CONFIG_ROM_SERIAL_OUT
);

  localparam logic [`ROM_DIV_W-1:0] ROM_HALF = `ROM_DIV_W'(`ROM_HALF_CYCLES);

  state_t r;
  state_t n;
  pins_t raw;
  logic [15:1] dec_addr;
  logic dec_qual_n;
  logic [15:1] s_addr;
  logic s_qual_n;
  logic sel_s;
  logic tick;
  logic bclk_rise;
  logic ads_rise;
  logic acc;
  logic [3:0] ev;
  logic setup;
  logic access;
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb begin
    raw.addr = ADDRESS;
    raw.qual_n = ADDRESS_QUALIFIER_N;
    raw.ads_n = ADDRESS_LATCH_STROBE_N;
    raw.rd_n = HOST_READ_STROBE_N;
    raw.wr_n = HOST_WRITE_STROBE_N;
    raw.wnr = SYNC_WRITE_NOT_READ;
    raw.cyc_n = COMMAND_CYCLE_N;
    raw.rdy_ret_n = READY_RETURN_IN_N;
    raw.bus_clk = BUS_CLK;
    raw.mode_n = SYNC_BUS_MODE_STRAP_N;
    raw.rom_en = CONFIG_ROM_ENABLE_STRAP;
    raw.rom_in = CONFIG_ROM_SERIAL_IN;
  end

  always_comb begin
    dec_addr = r.latch_mode ? r.lat_addr : ADDRESS;
    dec_qual_n = r.latch_mode ? r.lat_qual_n : ADDRESS_QUALIFIER_N;
  end

  assign LOCAL_DEVICE_SELECT_N_OUT = 1'b0;
  assign LOCAL_DEVICE_SELECT_N_OE = r.done & ~dec_qual_n &
    (dec_addr[`ADDR_CMP_HI:`ADDR_CMP_LO] == r.base[`ADDR_CMP_HI:`ADDR_CMP_LO]);

  assign IRQ_OUT_N_OUT = 1'b0;
  assign IRQ_OUT_N_OE = |(r.ist & r.imask);

  assign ASYNC_WAIT_READY_OUT = 1'b0;
  assign ASYNC_WAIT_READY_OE = r.async_wait_ready_drive;

  assign SYNC_READY_OUT_N = r.srdy_n;
  assign CONFIG_ROM_SELECT = r.cs;
  assign CONFIG_ROM_SERIAL_CLOCK = r.sk;
  assign CONFIG_ROM_SERIAL_OUT = r.do_bit;

  // zero-wait slave: read data is captured in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = r.prdata;
  assign PSLVERR = r.pslverr;

  always_comb begin
    s_addr = r.latch_mode ? r.lat_addr : r.s2.addr;
    s_qual_n = r.latch_mode ? r.lat_qual_n : r.s2.qual_n;
    sel_s = r.done & ~s_qual_n &
      (s_addr[`ADDR_CMP_HI:`ADDR_CMP_LO] == r.base[`ADDR_CMP_HI:`ADDR_CMP_LO]);
    tick = (r.div == ROM_HALF - `ROM_DIV_W'(1));
    bclk_rise = r.s2.bus_clk & ~r.bclk_d;
    ads_rise = r.s2.ads_n & ~r.ads_d;
    acc = r.mode_n & sel_s & (~r.s2.rd_n | ~r.s2.wr_n);
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE;
    rd_hit = 1'b1;
    case (PADDR)
      `REG_CTRL: rd_mux = {31'h0, r.latch_mode};
      `REG_BASE: rd_mux = {16'h0, r.base};
      `REG_STATUS: rd_mux = {27'h0, r.mode_n, r.bus16, r.rom_en, ~r.mode_n, r.done};
      `REG_ROM_WORD: rd_mux = {16'h0, r.rom_word};
      `REG_INT_STATUS: rd_mux = {28'h0, r.ist};
      `REG_INT_MASK: rd_mux = {28'h0, r.imask};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    n = r;
    ev = 4'h0;
    n.s1 = raw;
    n.s2 = r.s1;
    n.bclk_d = r.s2.bus_clk;
    n.ads_d = r.s2.ads_n;
    n.acc_d = acc;

    if (ads_rise) begin
      n.lat_addr = r.s2.addr;
      n.lat_qual_n = r.s2.qual_n;
    end

    if (r.rom == ROM_CMD || r.rom == ROM_DATA) begin
      n.div = tick ? `ROM_DIV_W'(0) : r.div + `ROM_DIV_W'(1);
      if (tick) begin
        n.sk = ~r.sk;
      end
    end

    case (r.rom)
      ROM_IDLE: begin
        // let the synchronisers fill before straps are trusted
        n.div = r.div + `ROM_DIV_W'(1);
        if (r.div == `ROM_WARM_CYCLES) begin
          n.div = `ROM_DIV_W'(0);
          n.rom = ROM_STRAP;
        end
      end
      ROM_STRAP: begin
        n.mode_n = r.s2.mode_n;
        n.rom_en = r.s2.rom_en;
        if (r.s2.rom_en) begin
          n.cs = 1'b1;
          n.cmd_sh = `ROM_CMD_WORD;
          n.do_bit = 1'(`ROM_CMD_WORD >> `ROM_CMD_MSB);
          n.bitcnt = 5'h0;
          n.rom = ROM_CMD;
        end else begin
          n.bus16 = ~r.s2.mode_n & r.s2.rom_in;
          n.done = 1'b1;
          ev[`INT_CFG_DONE] = 1'b1;
          n.rom = ROM_DONE;
        end
      end
      ROM_CMD: begin
        if (tick && r.sk) begin
          // shift command out on falling clock
          n.cmd_sh = {r.cmd_sh[7:0], 1'b0};
          n.do_bit = r.cmd_sh[7];
        end
        if (tick && !r.sk) begin
          n.bitcnt = r.bitcnt + 5'h1;
          if (r.bitcnt == `ROM_CMD_BITS - 5'h1) begin
            n.bitcnt = 5'h0;
            n.rom = ROM_DATA;
          end
        end
      end
      ROM_DATA: begin
        if (tick && r.sk) begin
          n.do_bit = 1'b0;
        end
        if (tick && !r.sk) begin
          // sample ROM data on rising clock
          n.rom_word = {r.rom_word[14:0], r.s2.rom_in};
          n.bitcnt = r.bitcnt + 5'h1;
          if (r.bitcnt == `ROM_DATA_BITS - 5'h1) begin
            n.rom = ROM_DONE;
            n.cs = 1'b0;
            n.sk = 1'b0;
            n.div = `ROM_DIV_W'(0);
            n.done = 1'b1;
            // width bit is read from the completed word, this last bit included
            n.bus16 = ~r.mode_n & n.rom_word[`ROM_WIDTH_BIT];
            ev[`INT_CFG_DONE] = 1'b1;
          end
        end
      end
      ROM_DONE: begin
        n.rom = ROM_DONE;
      end
      default: begin
        n.rom = ROM_IDLE;
      end
    endcase

    // sync ready on bus clock edges
    case (r.bus)
      B_IDLE: begin
        if (bclk_rise && !r.mode_n && sel_s && !r.s2.cyc_n) begin
          n.bus = B_CMD;
        end
      end
      B_CMD: begin
        if (bclk_rise) begin
          n.srdy_n = 1'b0;
          n.bus = B_READY;
          ev[`INT_SYNC] = 1'b1;
          ev[`INT_WRITE] = r.s2.wnr;
          ev[`INT_READ] = ~r.s2.wnr;
        end
      end
      B_READY: begin
        if (bclk_rise && (r.s2.wnr || !r.s2.rdy_ret_n)) begin
          n.srdy_n = 1'b1;
          n.bus = B_IDLE;
        end
      end
      default: begin
        n.bus = B_IDLE;
        n.srdy_n = 1'b1;
      end
    endcase

    // access direction is reported by the strobes in async mode
    if (acc && !r.acc_d) begin
      n.async_wait_ready_drive = 1'b1;
      n.wait_cnt = `ASYNC_WAIT_CYCLES;
      ev[`INT_READ] = ~r.s2.rd_n;
      ev[`INT_WRITE] = ~r.s2.wr_n;
    end else if (r.async_wait_ready_drive) begin
      n.wait_cnt = r.wait_cnt - 4'h1;
      if (r.wait_cnt == 4'h1) begin
        n.async_wait_ready_drive = 1'b0;
      end
    end
    if (!acc) begin
      n.async_wait_ready_drive = 1'b0;
    end

    // apb: snapshot read data and error in the setup cycle
    n.rd_clr = 4'h0;
    if (setup) begin
      n.prdata = PWRITE ? 32'h0 : rd_mux;
      n.pslverr = ~rd_hit;
      if (!PWRITE && PADDR == `REG_INT_STATUS) begin
        n.rd_clr = r.ist;
      end
    end else begin
      n.rd_clr = r.rd_clr;
    end
    if (access && PWRITE) begin
      case (PADDR)
        `REG_CTRL: n.latch_mode = PWDATA[`CTRL_LATCH_BIT];
        `REG_BASE: n.base = PWDATA[15:0];
        `REG_INT_MASK: n.imask = PWDATA[`INT_W-1:0];
        default: n.latch_mode = r.latch_mode;
      endcase
    end

    // sticky status; read clears only what was read, new events win
    n.ist = r.ist | ev;
    if (access && !PWRITE) begin
      n.ist = (r.ist & ~r.rd_clr) | ev;
      n.rd_clr = 4'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
      r.rom <= ROM_IDLE;
      r.bus <= B_IDLE;
      r.srdy_n <= 1'b1;
      r.base <= `BASE_RESET;
      // strobe copies start at their idle high level, so release gives no false edge
      r.s1.ads_n <= 1'b1;
      r.s2.ads_n <= 1'b1;
      r.ads_d <= 1'b1;
      r.s1.rd_n <= 1'b1;
      r.s2.rd_n <= 1'b1;
      r.s1.wr_n <= 1'b1;
      r.s2.wr_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

endmodule

//--- verif/host_bus_port_asserts.sv
// Purpose: port checks for host_bus_port
// Assumes: straps change only under reset
// Notes: latch mode is not watched
`timescale 1ns/1ps
module host_bus_port_asserts (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic ADDRESS_QUALIFIER_N,
  input wire logic SYNC_BUS_MODE_STRAP_N,
  input wire logic CONFIG_ROM_ENABLE_STRAP,
  input wire logic LOCAL_DEVICE_SELECT_N_OE,
  input wire logic ASYNC_WAIT_READY_OE,
  input wire logic SYNC_READY_OUT_N,
  input wire logic CONFIG_ROM_SELECT,
  input wire logic CONFIG_ROM_SERIAL_CLOCK,
  input wire logic CONFIG_ROM_SERIAL_OUT
);
  logic [8:0] hc;
  logic seen;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // cycles since the last serial clock edge; the first edge has no reference
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hc <= 9'h000;
      seen <= 1'b0;
    end else begin
      hc <= $changed(CONFIG_ROM_SERIAL_CLOCK) ? 9'h000 : hc + 9'h001;
      seen <= seen | $changed(CONFIG_ROM_SERIAL_CLOCK);
    end
  end
  a_sel_qual: assert property (
    ADDRESS_QUALIFIER_N |-> !LOCAL_DEVICE_SELECT_N_OE) else $error("select without qualifier");
  a_wait_len: assert property (
    $rose(ASYNC_WAIT_READY_OE) |-> ASYNC_WAIT_READY_OE[*4] ##1 !ASYNC_WAIT_READY_OE)
    else $error("wait length wrong");
  a_wait_cause: assert property (
    $rose(ASYNC_WAIT_READY_OE) |-> !ADDRESS_QUALIFIER_N && SYNC_BUS_MODE_STRAP_N)
    else $error("wait without access");
  a_wait_mode: assert property (
    !SYNC_BUS_MODE_STRAP_N |-> !ASYNC_WAIT_READY_OE) else $error("wait in sync mode");
  a_srdy_mode: assert property (
    SYNC_BUS_MODE_STRAP_N |-> SYNC_READY_OUT_N) else $error("sync ready in async mode");
  a_rom_absent: assert property (
    !CONFIG_ROM_ENABLE_STRAP |-> !CONFIG_ROM_SELECT && !CONFIG_ROM_SERIAL_CLOCK)
    else $error("rom used while absent");
  a_rom_half: assert property (
    $changed(CONFIG_ROM_SERIAL_CLOCK) && seen |-> hc == 9'h0c7)
    else $error("rom clock half period wrong");
  a_rom_data: assert property (
    $changed(CONFIG_ROM_SERIAL_OUT) |-> !CONFIG_ROM_SERIAL_CLOCK)
    else $error("rom data moved with clock high");
endmodule
bind host_bus_port host_bus_port_asserts chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .ADDRESS_QUALIFIER_N(ADDRESS_QUALIFIER_N), .SYNC_BUS_MODE_STRAP_N(SYNC_BUS_MODE_STRAP_N),
  .CONFIG_ROM_ENABLE_STRAP(CONFIG_ROM_ENABLE_STRAP),
  .LOCAL_DEVICE_SELECT_N_OE(LOCAL_DEVICE_SELECT_N_OE),
  .ASYNC_WAIT_READY_OE(ASYNC_WAIT_READY_OE), .SYNC_READY_OUT_N(SYNC_READY_OUT_N),
  .CONFIG_ROM_SELECT(CONFIG_ROM_SELECT), .CONFIG_ROM_SERIAL_CLOCK(CONFIG_ROM_SERIAL_CLOCK),
  .CONFIG_ROM_SERIAL_OUT(CONFIG_ROM_SERIAL_OUT));

//--- verif/config_rom_model.sv
// Purpose: serial configuration rom model
// Assumes: 9 command bits then 16 data bits
// Notes: released data line reads as its pull-down
`timescale 1ns/1ps
module config_rom_model #(parameter logic [15:0] WORD = 16'ha5c3) (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic dq
);
  logic [4:0] n = 5'h00;
  logic [8:0] cmd = 9'h000;
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      n <= 5'h00;
    end else begin
      if (n < 5'h09) cmd <= {cmd[7:0], di};
      n <= n + 5'h01;
    end
  end
  // data ready before the rising edge
  always @(negedge sk or negedge cs) begin
    dq <= (cs && n > 5'h08 && n < 5'h19) ? WORD[5'h18 - n] : 1'b0;
  end
endmodule

//--- verif/host_bus_port_tb.sv
// Purpose: self-checking bench for host_bus_port
// Assumes: host pins driven here, rom model on serial pins
// Notes: latch mode switched on for one select check, then off again
`timescale 1ns/1ps
`include "host_bus_defs.svh"
module host_bus_port_tb;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, pready, bon = 0, bclk = 0;
  logic qn = 1, host_read_strobe_n = 1, wrn = 1, wnr = 0, cycn = 1, rrn = 1, moden = 0, romen = 0, wid = 0;
  logic irq_oe, sel_oe, ar_oe, srdy_n, cs, sk, eo, rom_do;
  logic address_latch_strobe_n = 1, perr, irq_o, sel_o, ar_o;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic [15:1] addr = 15'h0000;
  logic [15:0] b;
  logic [63:0] e;
  logic [63:0] q[$];
  int n_fail = 0, n_compared = 0, seed = 41234;
  wire rom_in = romen ? rom_do : wid;
  always #5 clk = ~clk;
  // link clock stands still outside bus frames
  always #80 bclk = bon & ~bclk;
  host_bus_port dut_u (.SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .BUS_CLK(bclk),
    .ADDRESS(addr), .ADDRESS_QUALIFIER_N(qn), .ADDRESS_LATCH_STROBE_N(address_latch_strobe_n),
    .HOST_READ_STROBE_N(host_read_strobe_n), .HOST_WRITE_STROBE_N(wrn), .SYNC_WRITE_NOT_READ(wnr),
    .COMMAND_CYCLE_N(cycn), .READY_RETURN_IN_N(rrn), .SYNC_BUS_MODE_STRAP_N(moden),
    .CONFIG_ROM_ENABLE_STRAP(romen), .CONFIG_ROM_SERIAL_IN(rom_in), .IRQ_OUT_N_OUT(irq_o),
    .IRQ_OUT_N_OE(irq_oe), .LOCAL_DEVICE_SELECT_N_OUT(sel_o), .LOCAL_DEVICE_SELECT_N_OE(sel_oe),
    .ASYNC_WAIT_READY_OUT(ar_o), .ASYNC_WAIT_READY_OE(ar_oe), .SYNC_READY_OUT_N(srdy_n),
    .CONFIG_ROM_SELECT(cs), .CONFIG_ROM_SERIAL_CLOCK(sk), .CONFIG_ROM_SERIAL_OUT(eo));
  config_rom_model rom_u (.cs(cs), .sk(sk), .di(eo), .dq(rom_do));
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] m);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    if (!w) q.push_back({m, d & m});
    @(posedge clk);
    pen <= 1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prd;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wt(ref logic s, input logic v);
    int t = 0;
    while (s !== v && t < 400) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic rst(logic m, logic r);
    int t = 0;
    rst_b <= 0;
    moden <= m;
    romen <= r;
    wid <= 1'($random(seed));
    repeat (10) @(posedge clk);
    rst_b <= 1;
    do begin
      apb(0, `REG_STATUS, 32'h0, 32'h0);
      t++;
    end while (rdat[0] !== 1'b1 && t < 5000);
    if (rdat[0] !== 1'b1) n_fail++;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // read data is judged where the bus completes, oldest note first
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr) begin
      e = q.pop_front();
      chk("prdata", prd & e[63:32], e[31:0]);
    end
  end
  initial begin
    #600000;
    n_fail++;
    print_verdict();
  end
  initial begin
    rst(1, 1);
    chk("rom command", 32'(rom_u.cmd), 32'(`ROM_CMD_WORD));
    apb(0, `REG_ROM_WORD, 32'ha5c3, 32'hffff);
    apb(0, `REG_STATUS, 32'h15, 32'h1f);
    apb(0, `REG_BASE, 32'h300, 32'hffff);
    chk("slave error", perr, 0);
    apb(0, 12'h020, 32'h0, 32'hffffffff);
    chk("slave error", perr, 1);
    apb(1, `REG_INT_MASK, 32'h2, 32'h0);
    chk("irq masked", irq_oe, 0);
    chk("pin levels", {irq_o, sel_o, ar_o}, 0);
    apb(0, `REG_INT_STATUS, 32'h1, 32'hf);
    for (int i = 0; i < 2; i++) begin
      addr <= {12'h030, 3'($random(seed))};
      qn <= 0;
      host_read_strobe_n <= i[0];
      wrn <= !i[0];
      cycn <= !i[0];
      wt(ar_oe, 1);
      chk("wait ready", ar_oe, 1);
      repeat (6) @(posedge clk);
      chk("irq", irq_oe, 32'(!i[0]));
      host_read_strobe_n <= 1;
      wrn <= 1;
      cycn <= 1;
      qn <= 1;
      apb(0, `REG_INT_STATUS, 32'h2 << i, 32'he);
    end
    rst(0, 0);
    apb(0, `REG_STATUS, {27'h0, 1'b0, wid, 3'h3}, 32'h1f);
    b = 16'($random(seed));
    apb(1, `REG_BASE, {16'h0, b}, 32'h0);
    addr <= b[15:1];
    qn <= 0;
    #1 chk("select", sel_oe, 1);
    @(posedge clk) addr <= b[15:1] ^ 15'h0008;
    #1 chk("no select", sel_oe, 0);
    @(posedge clk) address_latch_strobe_n <= 0;
    addr <= b[15:1];
    apb(1, `REG_CTRL, 32'h1, 32'h0);
    address_latch_strobe_n <= 1;
    repeat (4) @(posedge clk);
    addr <= b[15:1] ^ 15'h0008;
    #1 chk("latched select", sel_oe, 1);
    @(posedge clk) addr <= b[15:1];
    apb(1, `REG_CTRL, 32'h0, 32'h0);
    apb(1, `REG_INT_MASK, 32'h8, 32'h0);
    cycn <= 0;
    bon <= 1;
    wt(srdy_n, 0);
    chk("sync ready", srdy_n, 0);
    cycn <= 1;
    rrn <= 0;
    wt(srdy_n, 1);
    chk("ready release", srdy_n, 1);
    chk("irq", irq_oe, 1);
    bon <= 0;
    qn <= 1;
    rrn <= 1;
    apb(0, `REG_INT_STATUS, 32'hb, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq clear", irq_oe, 0);
    print_verdict();
  end
endmodule
